// [shared/probe_defs.svh]
// constants for the analog probe and calibration select block
// assumes a serial command decoder that delivers decoded command strobes
//
// Function
// R1: node select picks which internal analog node drives the output pin
// R2: duration codes 0 to 14 hold the node for 2^N+1 byte times
// R3: code 15 holds the node forever, reception returns after 32769 bytes; here any later command other than readout ends it
// R4: calibration select 0..4 picks config, offset, offset tc, span, span tc
// R5: host never loads calibration with select code 5 or 6 to 15; the bench does so with dare set, and the block ignores such loads
// R6: host should load default coefficients first to avoid overload
// R7: readout command releases the serial pin and routes the node out
// R8: calibration load copies the 16-bit holding value to the chosen register
// R9: finite readout end restores amplifier output and command reception
`ifndef PROBE_DEFS_SVH
`define PROBE_DEFS_SVH

`define NODE_AMP_OUT 4'h0
`define NODE_BRIDGE_DRIVE 4'h1
`define NODE_BRIDGE_ISRC 4'h2
`define DUR_CONTINUOUS 4'hf
`define CONT_REENABLE_BYTES 16'h8001
`define LAST_BIT_INDEX 3'h7
`define CAL_SEL_CONFIG 4'h0
`define CAL_SEL_OFFSET 4'h1
`define CAL_SEL_OFFSET_TC 4'h2
`define CAL_SEL_SPAN 4'h3
`define CAL_SEL_SPAN_TC 4'h4
`define NODE_SELECT_RESET 4'h0
`define DURATION_RESET 4'h0
`define CAL_SELECT_RESET 4'h0
`define CAL_VALUE_RESET 16'h0000

`endif

// [shared/probe_pkg.sv]
// types shared by the analog probe and calibration select block
// assumes nothing beyond the constants header
`default_nettype none
package probe_pkg;

    typedef enum logic [1:0] {
        PROBE_IDLE = 2'b00,
        PROBE_TIMED = 2'b01,
        PROBE_CONT = 2'b10
    } probe_state_e;

    // one decoded command; at most one strobe high per cycle
    typedef struct packed {
        logic load_node;
        logic load_duration;
        logic load_cal_select;
        logic readout;
        logic cal_load;
        logic [3:0] nibble;
    } probe_cmd_s;

    typedef struct packed {
        logic [15:0] config_reg;
        logic [15:0] offset_dac;
        logic [15:0] offset_tempco_dac;
        logic [15:0] span_dac;
        logic [15:0] span_tempco_dac;
    } cal_bank_s;

endpackage
`default_nettype wire

// [rtl/analog_probe_and_cal_select.sv]
// analog readout node and timing control, calibration register loads
// assumes decoded command strobes and a learned bit period in clock cycles
`timescale 1ns/1ns
`default_nettype none
`include "probe_defs.svh"

module analog_probe_and_cal_select #(
    parameter int BIT_PERIOD_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire probe_pkg::probe_cmd_s cmd_in,
    input wire logic [15:0] data_holding_reg_in,
    input wire logic [BIT_PERIOD_W-1:0] bit_period_in,
    output logic [3:0] analog_node_out,
    output logic serial_drive_allow_out,
    output logic rx_enable_out,
    output logic readout_active_out,
    output probe_pkg::cal_bank_s cal_bank_out
);
    import probe_pkg::*;

    logic [3:0] analog_node_select;
    logic [3:0] analog_readout_duration;
    logic [3:0] calibration_register_select;
    probe_state_e state;
    probe_state_e next_state;
    logic [BIT_PERIOD_W-1:0] cycle_cnt;
    logic [2:0] bit_idx;
    logic [15:0] byte_cnt;
    logic byte_tick;
    logic accept;
    logic timed_expire;
    logic cont_release;

    // byte count for a duration code
    function automatic logic [15:0] duration_bytes(input logic [3:0] code);
        logic [15:0] pow;
        pow = 16'h0001 << code;
        duration_bytes = pow + 16'h0001;
    endfunction

    // commands only reach us while reception is enabled
    assign accept = rx_enable_out;
    assign byte_tick = (state != PROBE_IDLE)
        && (cycle_cnt == bit_period_in - BIT_PERIOD_W'(1))
        && (bit_idx == `LAST_BIT_INDEX);
    // R2: finite duration end
    assign timed_expire = (state == PROBE_TIMED) && byte_tick
        && (byte_cnt + 16'h0001
            == duration_bytes(analog_readout_duration));
    // R3: reception back after fixed count
    assign cont_release = (state == PROBE_CONT) && byte_tick
        && (byte_cnt + 16'h0001 == `CONT_REENABLE_BYTES);

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            analog_node_select <= `NODE_SELECT_RESET;
            analog_readout_duration <= `DURATION_RESET;
            calibration_register_select <= `CAL_SELECT_RESET;
        end
        else if (accept)
        begin
            if (cmd_in.load_node)
                analog_node_select <= cmd_in.nibble;
            if (cmd_in.load_duration)
                analog_readout_duration <= cmd_in.nibble;
            if (cmd_in.load_cal_select)
                calibration_register_select <= cmd_in.nibble;
        end
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            PROBE_IDLE:
            begin
                // R7: readout start
                if (accept && cmd_in.readout)
                begin
                    if (analog_readout_duration == `DUR_CONTINUOUS)
                        next_state = PROBE_CONT;
                    else
                        next_state = PROBE_TIMED;
                end
            end
            PROBE_TIMED:
            begin
                // R9: return to amplifier
                if (timed_expire)
                    next_state = PROBE_IDLE;
            end
            PROBE_CONT:
            begin
                // any command other than readout after release ends continuous readout
                if (accept && (cmd_in.load_node || cmd_in.load_duration
                    || cmd_in.load_cal_select || cmd_in.cal_load))
                    next_state = PROBE_IDLE;
            end
            default:
                next_state = PROBE_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            state <= PROBE_IDLE;
        else
            state <= next_state;
    end

    // R2: bit and byte divider
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cycle_cnt <= '0;
            bit_idx <= 3'h0;
            byte_cnt <= 16'h0000;
        end
        else if (state == PROBE_IDLE || next_state == PROBE_IDLE)
        begin
            cycle_cnt <= '0;
            bit_idx <= 3'h0;
            byte_cnt <= 16'h0000;
        end
        else if (cycle_cnt == bit_period_in - BIT_PERIOD_W'(1))
        begin
            cycle_cnt <= '0;
            bit_idx <= bit_idx + 3'h1;
            if (byte_tick && byte_cnt != `CONT_REENABLE_BYTES)
                byte_cnt <= byte_cnt + 16'h0001;
        end
        else
            cycle_cnt <= cycle_cnt + BIT_PERIOD_W'(1);
    end

    // R1: node routing and pin control
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            analog_node_out <= `NODE_AMP_OUT;
            serial_drive_allow_out <= 1'b1;
            rx_enable_out <= 1'b1;
            readout_active_out <= 1'b0;
        end
        else
        begin
            readout_active_out <= (next_state != PROBE_IDLE);
            serial_drive_allow_out <= (next_state == PROBE_IDLE);
            if (next_state == PROBE_IDLE)
                analog_node_out <= `NODE_AMP_OUT;
            else
                analog_node_out <= analog_node_select;
            if (next_state == PROBE_IDLE || cont_release)
                rx_enable_out <= 1'b1;
            else if (next_state == PROBE_TIMED || state == PROBE_IDLE)
                rx_enable_out <= 1'b0;
        end
    end

    // R8: calibration register load
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            cal_bank_out <= {5{`CAL_VALUE_RESET}};
        else if (accept && cmd_in.cal_load)
        begin
            // R4: select decode, reserved codes ignored
            unique case (calibration_register_select)
                `CAL_SEL_CONFIG:
                    cal_bank_out.config_reg <= data_holding_reg_in;
                `CAL_SEL_OFFSET:
                    cal_bank_out.offset_dac <= data_holding_reg_in;
                `CAL_SEL_OFFSET_TC:
                    cal_bank_out.offset_tempco_dac <= data_holding_reg_in;
                `CAL_SEL_SPAN:
                    cal_bank_out.span_dac <= data_holding_reg_in;
                `CAL_SEL_SPAN_TC:
                    cal_bank_out.span_tempco_dac <= data_holding_reg_in;
                default:
                    cal_bank_out <= cal_bank_out;
            endcase
        end
    end

    a_idle_node_amp: assert property (@(posedge sys_clk_in) // R9
        disable iff (!rst_b_in)
        (state == PROBE_IDLE) |-> (analog_node_out == `NODE_AMP_OUT)
            && rx_enable_out && serial_drive_allow_out)
        else $error("idle state does not show amplifier output");

    a_readout_release_pin: assert property (@(posedge sys_clk_in) // R7
        disable iff (!rst_b_in)
        (state == PROBE_IDLE && accept && cmd_in.readout) |=>
            !serial_drive_allow_out && !rx_enable_out
            && analog_node_out == $past(analog_node_select))
        else $error("readout did not release pin or route node");

    a_node_held_timed: assert property (@(posedge sys_clk_in) // R1
        disable iff (!rst_b_in)
        (state != PROBE_IDLE) |-> analog_node_out == analog_node_select)
        else $error("selected node not on output during readout");

    a_timed_byte_count: assert property (@(posedge sys_clk_in) // R2
        disable iff (!rst_b_in)
        (state == PROBE_TIMED && $past(state) == PROBE_IDLE
            && analog_readout_duration == 4'h0)
        |-> (state == PROBE_TIMED)[*8])
        else $error("two byte readout ended too soon");

    a_timed_expire_idle: assert property (@(posedge sys_clk_in) // R2
        disable iff (!rst_b_in)
        timed_expire |=> state == PROBE_IDLE && rx_enable_out
            && $past(byte_cnt) == duration_bytes(analog_readout_duration)
                - 16'h0001)
        else $error("finite readout did not end at its byte count");

    a_cont_reenable: assert property (@(posedge sys_clk_in) // R3
        disable iff (!rst_b_in)
        cont_release |=> rx_enable_out && state == PROBE_CONT
            && !serial_drive_allow_out)
        else $error("continuous readout did not re-enable reception");

    a_cont_rx_off: assert property (@(posedge sys_clk_in) // R3
        disable iff (!rst_b_in)
        (state == PROBE_CONT && byte_cnt < 16'h8000 && $past(state) ==
            PROBE_CONT) |-> !rx_enable_out)
        else $error("reception came back early in continuous mode");

    a_cal_load_span: assert property (@(posedge sys_clk_in) // R8
        disable iff (!rst_b_in)
        (accept && cmd_in.cal_load
            && calibration_register_select == `CAL_SEL_SPAN)
        |=> cal_bank_out.span_dac == $past(data_holding_reg_in)
            && $stable(cal_bank_out.offset_dac))
        else $error("span load did not copy holding value");

    a_cal_select_offset: assert property (@(posedge sys_clk_in) // R4
        disable iff (!rst_b_in)
        (accept && cmd_in.cal_load
            && calibration_register_select == `CAL_SEL_OFFSET)
        |=> cal_bank_out.offset_dac == $past(data_holding_reg_in)
            && $stable(cal_bank_out.span_dac))
        else $error("offset select decoded wrongly");

endmodule
`default_nettype wire

// [bench/host_model.sv]
// host side model: issues decoded command strobes
// assumes the bench calls send just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic clk_in,
    input wire logic rx_enable_in,
    output var probe_pkg::probe_cmd_s cmd_out,
    output var logic [15:0] dhr_out
);
    import probe_pkg::*;
    logic [3:0] cur_sel = 4'h0;
    initial cmd_out = '0;
    initial dhr_out = 16'h0000;
    // k: 0 node, 1 duration, 2 cal select, 3 readout, 4 cal load
    task automatic send(input int k, input logic [3:0] nib,
        input logic [15:0] val, input bit dare);
        probe_cmd_s c;
        c = '0;
        c.nibble = nib;
        c.load_node = (k == 0);
        c.load_duration = (k == 1);
        c.load_cal_select = (k == 2);
        c.readout = (k == 3);
        c.cal_load = (k == 4);
        if (k == 2)
            cur_sel = nib;
        if (k == 4 && cur_sel > 4'h4 && !dare)
            return;
        while (rx_enable_in !== 1'b1)
            @(posedge clk_in) #1;
        dhr_out = val;
        cmd_out = c;
        @(posedge clk_in) #1;
        cmd_out = '0;
        // one idle edge so the next strobe is a fresh assignment
        @(posedge clk_in) #1;
    endtask
endmodule
`default_nettype wire

// [bench/analog_probe_and_cal_select_tb.sv]
// self-checking bench for the probe and calibration select block
// assumes the host model as the only command source
`timescale 1ns/1ns
`default_nettype none
module analog_probe_and_cal_select_tb;
    import probe_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [15:0] bit_period = 16'h0001;
    probe_cmd_s cmd;
    logic [15:0] data_holding_reg;
    logic [3:0] node;
    logic [3:0] start_node;
    logic drive_ok, rx_en, active, bad;
    cal_bank_s bank, prev_bank, exp_bank;
    cal_bank_s bank_q[$];
    logic [42:0] ro_q[$];
    logic [31:0] seed = 32'hd0092983;
    int run_len = 0;
    int n_errors = 0;
    int compares = 0;
    logic [86:0] pins;
    assign pins = {bank, node, rx_en, drive_ok, active};
    always #2 sys_clk_in = ~sys_clk_in;
    host_model u_host_model (.clk_in(sys_clk_in), .rx_enable_in(rx_en),
        .cmd_out(cmd), .dhr_out(data_holding_reg));
    analog_probe_and_cal_select u_analog_probe_and_cal_select (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cmd_in(cmd),
        .data_holding_reg_in(data_holding_reg), .bit_period_in(bit_period),
        .analog_node_out(node), .serial_drive_allow_out(drive_ok),
        .rx_enable_out(rx_en), .readout_active_out(active),
        .cal_bank_out(bank));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic fail(input string msg);
        n_errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    task automatic check_bank(input cal_bank_s got);
        cal_bank_s exp;
        exp = bank_q.size() ? bank_q.pop_front() : ~got;
        compares++;
        if (got !== exp)
            fail("calibration bank mismatch");
    endtask
    task automatic check_ro(input logic [42:0] got);
        logic [42:0] exp;
        exp = ro_q.size() ? ro_q.pop_front() : '0;
        compares++;
        if (got !== exp)
            fail("readout mismatch");
    endtask
    task automatic check_pins(input logic [86:0] got, input logic [86:0] exp);
        compares++;
        if (got !== exp)
            fail("pin state mismatch");
    endtask
    task automatic tally_and_finish;
        if (bank_q.size() + ro_q.size() != 0)
            fail("notes left over");
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // result watcher on the falling edge, where outputs are settled
    always @(negedge sys_clk_in)
    begin
        if (rst_b_in !== 1'b1)
        begin
            prev_bank = bank;
            run_len = 0;
        end
        else
        begin
            if (bank !== prev_bank)
                check_bank(bank);
            prev_bank = bank;
            if (active === 1'b1)
            begin
                if (run_len == 0)
                begin
                    start_node = node;
                    bad = 1'b0;
                end
                bad = bad | rx_en | drive_ok;
                run_len++;
            end
            else if (run_len > 0)
            begin
                check_ro({start_node, bad, node, rx_en, drive_ok,
                    32'(run_len)});
                run_len = 0;
            end
        end
    end
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        #1 rst_b_in = 1'b1;
        exp_bank = '0;
        @(posedge sys_clk_in) #1;
        check_pins(pins, {84'h0, 3'b110});
        $display("test reset done");
        for (int s = 0; s < 16; s++)
        begin
            seed = xs(seed);
            u_host_model.send(2, 4'(s), 16'h0000, 1'b0);
            if (s < 5)
            begin
                exp_bank[79 - 16 * s -: 16] = seed[15:0];
                bank_q.push_back(exp_bank);
            end
            u_host_model.send(4, 4'h0, seed[15:0], s > 4);
        end
        $display("test calibration loads done");
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            bit_period = {14'h0000, seed[1:0] | 2'b01};
            u_host_model.send(0, 4'(i), 16'h0000, 1'b0);
            u_host_model.send(1, 4'(i % 6), 16'h0000, 1'b0);
            ro_q.push_back({4'(i), 5'h00, 2'b11,
                32'(8 * int'(bit_period) * ((1 << (i % 6)) + 1))});
            u_host_model.send(3, 4'h0, 16'h0000, 1'b0);
            wait (rx_en === 1'b1);
            @(posedge sys_clk_in) #1;
        end
        $display("test timed readouts done");
        u_host_model.send(1, 4'hf, 16'h0000, 1'b0);
        u_host_model.send(3, 4'h0, 16'h0000, 1'b0);
        repeat (600) @(posedge sys_clk_in);
        #1;
        check_pins(pins, {exp_bank, 4'hf, 3'b001});
        rst_b_in = 1'b0;
        repeat (3) @(posedge sys_clk_in);
        #1 rst_b_in = 1'b1;
        check_pins(pins, {84'h0, 3'b110});
        $display("test continuous readout done");
        tally_and_finish;
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk_in);
        fail("watchdog expired");
        tally_and_finish;
    end
endmodule
`default_nettype wire
